// File: hdl/flash_isp_status.sv
/*
 Flash programming status and trigger block with AXI4-Lite registers,
 operation sequencing toward the flash array and one level interrupt.
 Assumes flash array, config words and write-lock logic share ref_clk.
*/
// Function
// [RULE1] Bits 20:9 read the 12-bit vector page the lowest page maps to.
// [RULE2] Fail flag sets when application flash programs itself.
// [RULE3] Fail flag sets when loader flash programs itself.
// [RULE4] Fail flag sets on config word write while config update disabled.
// [RULE5] Fail flag sets on an illegal destination address.
// [RULE6] Writing one clears the fail flag; writing zero does nothing.
// [RULE7] Fail flag clears only while register write protection is unlocked.
// [RULE8] Fail flag is one state shared with control register bit 6.
// [RULE9] Bits 2:1 mirror the boot selection of config word zero.
// [RULE10] Writing one to bit 0 starts; hardware clears it on completion.
// [RULE11] Bit 0 reads one while running and zero when finished.
// [RULE12] Start trigger is one state shared with trigger register bit 0.
// [RULE13] Reserved status bits read zero and ignore writes.
`timescale 1ns/100ps
module flash_isp_status import flash_isp_pkg::*; #(
	parameter int ADDR_W = 8
) (
	input wire logic ref_clk,
	input wire logic nrst,
	input wire logic awvalid,
	output logic awready,
	input wire logic [ADDR_W-1:0] awaddr,
	input wire logic wvalid,
	output logic wready,
	input wire logic [31:0] wdata,
	input wire logic [3:0] wstrb,
	output logic bvalid,
	input wire logic bready,
	output logic [1:0] bresp,
	input wire logic arvalid,
	output logic arready,
	input wire logic [ADDR_W-1:0] araddr,
	output logic rvalid,
	input wire logic rready,
	output logic [31:0] rdata,
	output logic [1:0] rresp,
	input wire logic [VEC_W-1:0] vectorPageMap,
	input wire logic [1:0] configBootSelect,
	input wire logic regUnlocked,
	input wire logic [31:0] opAddr,
	input wire logic opWrites,
	input wire logic execApp,
	input wire logic execLoader,
	input wire logic flashDone,
	output logic flashStart,
	output logic irq
);
	if (ADDR_W < 8 || ADDR_W > 32) begin
		$error("flash_isp_status: ADDR_W must be 8 to 32");
	end

	// ---------------------------------------------------------------
	// Bus front end
	// ---------------------------------------------------------------
	logic wrEn, rdEn, wrErr, rdErr;
	logic [ADDR_W-1:0] wrAddr, rdAddr;
	logic [31:0] wrData, rdDataIn;
	logic [3:0] wrStrb;

	axil_regport #(.ADDR_W(ADDR_W)) u_port (
		.ref_clk(ref_clk),
		.nrst(nrst),
		.awvalid(awvalid),
		.awready(awready),
		.awaddr(awaddr),
		.wvalid(wvalid),
		.wready(wready),
		.wdata(wdata),
		.wstrb(wstrb),
		.bvalid(bvalid),
		.bready(bready),
		.bresp(bresp),
		.arvalid(arvalid),
		.arready(arready),
		.araddr(araddr),
		.rvalid(rvalid),
		.rready(rready),
		.rdata(rdata),
		.rresp(rresp),
		.wrEn(wrEn),
		.wrAddr(wrAddr),
		.wrData(wrData),
		.wrStrb(wrStrb),
		.wrErr(wrErr),
		.rdEn(rdEn),
		.rdAddr(rdAddr),
		.rdDataIn(rdDataIn),
		.rdErr(rdErr)
	);

	function automatic logic isAt(input logic [ADDR_W-1:0] a,
		input logic [7:0] off);
		return a == ADDR_W'(off);
	endfunction

	function automatic logic isMapped(input logic [ADDR_W-1:0] a);
		return isAt(a, CTRL_OFF) | isAt(a, TRIG_OFF) |
			isAt(a, ISP_STATUS_OFF) | isAt(a, IRQ_STAT_OFF) |
			isAt(a, IRQ_MASK_OFF);
	endfunction

	// ---------------------------------------------------------------
	// Write decode
	// ---------------------------------------------------------------
	isp_state_t state, next_state;
	logic failFlag, cfgUpdateEn;
	logic [IRQ_W-1:0] irqStat, irqMask;
	logic failApp, failLoader, failCfg, failRange;

	wire lane0 = wrStrb[0];
	wire wrStatus = wrEn & lane0 & isAt(wrAddr, ISP_STATUS_OFF);
	wire wrCtrl = wrEn & lane0 & isAt(wrAddr, CTRL_OFF);
	wire wrTrig = wrEn & lane0 & isAt(wrAddr, TRIG_OFF);
	wire wrIrqStat = wrEn & lane0 & isAt(wrAddr, IRQ_STAT_OFF);
	wire wrIrqMask = wrEn & lane0 & isAt(wrAddr, IRQ_MASK_OFF);
	assign wrErr = ~isMapped(wrAddr);
	assign rdErr = ~isMapped(rdAddr);

	wire busy = state == stRun;
	wire failClear = (wrStatus | wrCtrl) & wrData[FAIL_BIT] &
		regUnlocked; // [RULE6] [RULE7] [RULE8]
	wire startReq = (wrStatus | wrTrig) & wrData[GO_BIT] &
		~busy; // [RULE10] [RULE12]
	wire anyFail = failApp | failLoader | failCfg | failRange;
	wire failSet = startReq & anyFail;
	wire goAccept = startReq & ~anyFail;
	wire opEnd = busy & flashDone;
	wire cfgWrite = wrCtrl & regUnlocked;

	isp_guard u_guard (
		.opAddr(opAddr),
		.opWrites(opWrites),
		.execApp(execApp),
		.execLoader(execLoader),
		.cfgUpdateEn(cfgUpdateEn),
		.failApp(failApp),
		.failLoader(failLoader),
		.failCfg(failCfg),
		.failRange(failRange)
	);

	// ---------------------------------------------------------------
	// Next values
	// ---------------------------------------------------------------
	wire next_failFlag = failSet | (failFlag & ~failClear); // [RULE2] [RULE6]
	wire next_cfgUpdateEn = cfgWrite ? wrData[CFG_EN_BIT] : cfgUpdateEn;
	wire [IRQ_W-1:0] irqEvent = {failSet, opEnd};
	wire [IRQ_W-1:0] irqClr = wrIrqStat ? wrData[IRQ_W-1:0] : '0;
	wire [IRQ_W-1:0] next_irqStat = irqEvent | (irqStat & ~irqClr);
	wire [IRQ_W-1:0] next_irqMask = wrIrqMask ? wrData[IRQ_W-1:0] : irqMask;

	always_comb begin
		next_state = state;
		unique case (state)
			stIdle: if (goAccept) next_state = stRun;
			stRun: if (flashDone) next_state = stIdle; // [RULE10]
		endcase
	end

	always_ff @(posedge ref_clk) begin
		if (!nrst) begin
			state <= stIdle;
			failFlag <= ISP_STATUS_RST[FAIL_BIT];
			cfgUpdateEn <= CFG_EN_RST;
			irqStat <= '0;
			irqMask <= '0;
			flashStart <= 1'h0;
			irq <= IRQ_RST;
		end else begin
			state <= next_state;
			failFlag <= next_failFlag;
			cfgUpdateEn <= next_cfgUpdateEn;
			irqStat <= next_irqStat;
			irqMask <= next_irqMask;
			flashStart <= goAccept;
			irq <= |(next_irqStat & next_irqMask);
		end
	end

	// ---------------------------------------------------------------
	// Read view
	// ---------------------------------------------------------------
	wire [31:0] statusWord = {11'h000, vectorPageMap, 2'h0, failFlag, 3'h0,
		configBootSelect, busy}; // [RULE1] [RULE9] [RULE11] [RULE13]
	wire [31:0] ctrlWord = {25'h0000000, failFlag, 1'h0, cfgUpdateEn,
		4'h0}; // [RULE8]
	wire [31:0] trigWord = {31'h00000000, busy}; // [RULE12]
	wire [31:0] irqStatWord = {30'h00000000, irqStat};
	wire [31:0] irqMaskWord = {30'h00000000, irqMask};

	assign rdDataIn = isAt(rdAddr, ISP_STATUS_OFF) ? statusWord :
		isAt(rdAddr, CTRL_OFF) ? ctrlWord :
		isAt(rdAddr, TRIG_OFF) ? trigWord :
		isAt(rdAddr, IRQ_STAT_OFF) ? irqStatWord :
		isAt(rdAddr, IRQ_MASK_OFF) ? irqMaskWord : 32'h0000_0000;

	// ---------------------------------------------------------------
	// Checks
	// ---------------------------------------------------------------
	wire rdStatus = rdEn & isAt(rdAddr, ISP_STATUS_OFF);
	wire rdCtrl = rdEn & isAt(rdAddr, CTRL_OFF);

	a_vector_page_read: assert property ( // [RULE1]
		@(posedge ref_clk) disable iff (!nrst)
		rdStatus |=> rvalid && rdata[20:9] == $past(vectorPageMap))
		else $error("vector page field wrong");

	a_fail_app_self: assert property ( // [RULE2]
		@(posedge ref_clk) disable iff (!nrst)
		startReq && failApp |=> failFlag && !busy && !flashStart)
		else $error("application self write not flagged");

	a_fail_loader_self: assert property ( // [RULE3]
		@(posedge ref_clk) disable iff (!nrst)
		startReq && failLoader |=> failFlag && $stable(state))
		else $error("loader self write not flagged");

	a_fail_cfg_lock: assert property ( // [RULE4]
		@(posedge ref_clk) disable iff (!nrst)
		startReq && opWrites && failCfg && !cfgUpdateEn |=> failFlag)
		else $error("locked config write not flagged");

	a_fail_bad_addr: assert property ( // [RULE5]
		@(posedge ref_clk) disable iff (!nrst)
		startReq && failRange |=> failFlag ##1 !flashStart)
		else $error("illegal address not flagged");

	a_fail_irq_event: assert property ( // [RULE5]
		@(posedge ref_clk) disable iff (!nrst)
		startReq && anyFail |=> irqStat[IRQ_FAIL_BIT])
		else $error("fail event not recorded");

	a_fail_w1c: assert property ( // [RULE6]
		@(posedge ref_clk) disable iff (!nrst)
		wrStatus && wrData[FAIL_BIT] && regUnlocked && !failSet
		|=> !failFlag)
		else $error("fail flag not cleared by one");

	a_fail_zero_write: assert property ( // [RULE6]
		@(posedge ref_clk) disable iff (!nrst)
		wrStatus && !wrData[FAIL_BIT] && failFlag |=> failFlag)
		else $error("fail flag cleared by zero");

	a_fail_locked: assert property ( // [RULE7]
		@(posedge ref_clk) disable iff (!nrst)
		failFlag && !regUnlocked |=> failFlag)
		else $error("fail flag cleared while locked");

	a_fail_shared: assert property ( // [RULE8]
		@(posedge ref_clk) disable iff (!nrst)
		rdCtrl |=> rdata[FAIL_BIT] == $past(failFlag))
		else $error("control bit 6 differs from fail flag");

	a_fail_ctrl_clear: assert property ( // [RULE8]
		@(posedge ref_clk) disable iff (!nrst)
		wrCtrl && wrData[FAIL_BIT] && regUnlocked && !failSet
		|=> !failFlag)
		else $error("control bit 6 did not clear fail flag");

	a_boot_mirror: assert property ( // [RULE9]
		@(posedge ref_clk) disable iff (!nrst)
		rdStatus |=> rdata[2:1] == $past(configBootSelect))
		else $error("boot select copy wrong");

	a_go_sequence: assert property ( // [RULE10]
		@(posedge ref_clk) disable iff (!nrst)
		goAccept |=> flashStart && busy ##1 !flashStart)
		else $error("start not issued");

	a_go_self_clear: assert property ( // [RULE10]
		@(posedge ref_clk) disable iff (!nrst)
		busy && flashDone |=> !busy && irqStat[IRQ_DONE_BIT])
		else $error("trigger not cleared at completion");

	a_go_busy_ignored: assert property ( // [RULE10]
		@(posedge ref_clk) disable iff (!nrst)
		busy && (wrStatus || wrTrig) && wrData[GO_BIT] |=> !flashStart)
		else $error("trigger while busy restarted flash");

	a_go_readback: assert property ( // [RULE11]
		@(posedge ref_clk) disable iff (!nrst)
		rdStatus |=> rdata[GO_BIT] == $past(busy))
		else $error("trigger readback wrong");

	a_go_shared: assert property ( // [RULE12]
		@(posedge ref_clk) disable iff (!nrst)
		wrTrig && wrData[GO_BIT] && !busy && !anyFail |=> busy)
		else $error("trigger register did not start");

	a_trig_readback: assert property ( // [RULE12]
		@(posedge ref_clk) disable iff (!nrst)
		rdEn && isAt(rdAddr, TRIG_OFF) |=> rdata == {31'h0, $past(busy)})
		else $error("trigger register readback wrong");

	a_reserved_zero: assert property ( // [RULE13]
		@(posedge ref_clk) disable iff (!nrst)
		rdStatus |=> rdata[31:21] == 11'h000 && rdata[8:7] == 2'h0 &&
			rdata[5:3] == 3'h0)
		else $error("reserved status bits not zero");
endmodule

// File: hdl/flash_isp_pkg.sv
/*
 Constants shared by the flash programming status block: register offsets,
 field positions, reset values and default flash region bounds.
 Assumes a 32-bit AXI4-Lite register port with byte addressing.
*/
package flash_isp_pkg;
	// ---------------------------------------------------------------
	// Register offsets (byte addresses)
	// ---------------------------------------------------------------
	localparam logic [7:0] CTRL_OFF = 8'h00;
	localparam logic [7:0] TRIG_OFF = 8'h10;
	localparam logic [7:0] ISP_STATUS_OFF = 8'h40;
	localparam logic [7:0] IRQ_STAT_OFF = 8'h44;
	localparam logic [7:0] IRQ_MASK_OFF = 8'h48;
	// ---------------------------------------------------------------
	// Field positions
	// ---------------------------------------------------------------
	localparam int GO_BIT = 0;
	localparam int BOOT_LSB = 1;
	localparam int CFG_EN_BIT = 4;
	localparam int FAIL_BIT = 6;
	localparam int VEC_LSB = 9;
	localparam int VEC_W = 12;
	localparam int IRQ_DONE_BIT = 0;
	localparam int IRQ_FAIL_BIT = 1;
	localparam int IRQ_W = 2;
	// ---------------------------------------------------------------
	// Reset values
	// ---------------------------------------------------------------
	localparam logic [31:0] ISP_STATUS_RST = 32'h0000_0000;
	localparam logic IRQ_RST = 1'h0;
	localparam logic CFG_EN_RST = 1'h0;
	// ---------------------------------------------------------------
	// Bus answers
	// ---------------------------------------------------------------
	localparam logic [1:0] RESP_OKAY = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;
	// ---------------------------------------------------------------
	// Default flash regions
	// ---------------------------------------------------------------
	localparam logic [31:0] APP_LO_DEF = 32'h0000_0000;
	localparam logic [31:0] APP_HI_DEF = 32'h0001_FFFF;
	localparam logic [31:0] LDR_LO_DEF = 32'h0010_0000;
	localparam logic [31:0] LDR_HI_DEF = 32'h0010_0FFF;
	localparam logic [31:0] CFG_LO_DEF = 32'h0030_0000;
	localparam logic [31:0] CFG_HI_DEF = 32'h0030_0007;

	typedef enum logic {stIdle, stRun} isp_state_t;
endpackage

// File: hdl/axil_regport.sv
/*
 AXI4-Lite slave front end: takes address and data in either order,
 gives one-cycle write and read strobes to the register file, answers.
 Assumes the register file returns read data and errors combinationally.
*/
`timescale 1ns/100ps
module axil_regport import flash_isp_pkg::*; #(
	parameter int ADDR_W = 8
) (
	input wire logic ref_clk,
	input wire logic nrst,
	input wire logic awvalid,
	output logic awready,
	input wire logic [ADDR_W-1:0] awaddr,
	input wire logic wvalid,
	output logic wready,
	input wire logic [31:0] wdata,
	input wire logic [3:0] wstrb,
	output logic bvalid,
	input wire logic bready,
	output logic [1:0] bresp,
	input wire logic arvalid,
	output logic arready,
	input wire logic [ADDR_W-1:0] araddr,
	output logic rvalid,
	input wire logic rready,
	output logic [31:0] rdata,
	output logic [1:0] rresp,
	output logic wrEn,
	output logic [ADDR_W-1:0] wrAddr,
	output logic [31:0] wrData,
	output logic [3:0] wrStrb,
	input wire logic wrErr,
	output logic rdEn,
	output logic [ADDR_W-1:0] rdAddr,
	input wire logic [31:0] rdDataIn,
	input wire logic rdErr
);
	logic awHeld, wHeld, arHeld;
	logic next_awHeld, next_wHeld, next_arHeld, next_bvalid, next_rvalid;

	assign wrEn = awHeld & wHeld & ~bvalid;
	assign rdEn = arHeld & ~rvalid;
	assign next_bvalid = (bvalid & ~bready) | wrEn;
	assign next_rvalid = (rvalid & ~rready) | rdEn;
	assign next_awHeld = (awHeld | (awvalid & awready)) & ~wrEn;
	assign next_wHeld = (wHeld | (wvalid & wready)) & ~wrEn;
	assign next_arHeld = (arHeld | (arvalid & arready)) & ~rdEn;

	always_ff @(posedge ref_clk) begin
		if (!nrst) begin
			{awHeld, wHeld, arHeld, bvalid, rvalid} <= 5'h00;
			{awready, wready, arready} <= 3'h0;
		end else begin
			{awHeld, wHeld, arHeld} <= {next_awHeld, next_wHeld, next_arHeld};
			{bvalid, rvalid} <= {next_bvalid, next_rvalid};
			awready <= ~next_awHeld & ~next_bvalid;
			wready <= ~next_wHeld & ~next_bvalid;
			arready <= ~next_arHeld & ~next_rvalid;
		end
	end

	always_ff @(posedge ref_clk) begin
		if (!nrst) begin
			wrAddr <= '0;
			rdAddr <= '0;
			wrData <= 32'h0000_0000;
			wrStrb <= 4'h0;
			bresp <= RESP_OKAY;
			rdata <= 32'h0000_0000;
			rresp <= RESP_OKAY;
		end else begin
			if (awvalid & awready) wrAddr <= awaddr;
			if (wvalid & wready) begin
				wrData <= wdata;
				wrStrb <= wstrb;
			end
			if (arvalid & arready) rdAddr <= araddr;
			if (wrEn) bresp <= wrErr ? RESP_SLVERR : RESP_OKAY;
			if (rdEn) begin
				rdata <= rdDataIn;
				rresp <= rdErr ? RESP_SLVERR : RESP_OKAY;
			end
		end
	end
endmodule

// File: hdl/isp_guard.sv
/*
 Legality check of a triggered flash operation against the flash regions.
 Assumes operation address and execution region come on the system clock.
*/
`timescale 1ns/100ps
module isp_guard import flash_isp_pkg::*; #(
	parameter logic [31:0] APP_LO = APP_LO_DEF,
	parameter logic [31:0] APP_HI = APP_HI_DEF,
	parameter logic [31:0] LDR_LO = LDR_LO_DEF,
	parameter logic [31:0] LDR_HI = LDR_HI_DEF,
	parameter logic [31:0] CFG_LO = CFG_LO_DEF,
	parameter logic [31:0] CFG_HI = CFG_HI_DEF
) (
	input wire logic [31:0] opAddr,
	input wire logic opWrites,
	input wire logic execApp,
	input wire logic execLoader,
	input wire logic cfgUpdateEn,
	output logic failApp,
	output logic failLoader,
	output logic failCfg,
	output logic failRange
);
	if (APP_LO > APP_HI || LDR_LO > LDR_HI || CFG_LO > CFG_HI) begin
		$error("isp_guard: region bounds inverted");
	end

	function automatic logic inRange(input logic [31:0] a,
		input logic [31:0] lo, input logic [31:0] hi);
		return (a >= lo) && (a <= hi);
	endfunction

	wire inApp = inRange(opAddr, APP_LO, APP_HI);
	wire inLdr = inRange(opAddr, LDR_LO, LDR_HI);
	wire inCfg = inRange(opAddr, CFG_LO, CFG_HI);

	assign failApp = opWrites & inApp & execApp; // [RULE2]
	assign failLoader = opWrites & inLdr & execLoader; // [RULE3]
	assign failCfg = opWrites & inCfg & ~cfgUpdateEn; // [RULE4]
	assign failRange = ~(inApp | inLdr | inCfg); // [RULE5]
endmodule

// File: verification/flash_array_model.sv
/*
 Behavioural model of the flash array behind the programming block.
 Assumes one start pulse per operation and the bench's ref_clk and nrst.
*/
`timescale 1ns/100ps
module flash_array_model (
	input wire logic ref_clk,
	input wire logic nrst,
	input wire logic flashStart,
	input wire logic [7:0] doneDelay,
	output logic flashDone
);
	logic running;
	logic [7:0] count;

	// ---------------------------------------------------------------
	// Operation timing, prompt or slow as the bench asks
	// ---------------------------------------------------------------
	always @(posedge ref_clk) begin
		if (!nrst) begin
			running <= 1'b0;
			count <= 8'h00;
			flashDone <= 1'b0;
		end else begin
			flashDone <= 1'b0;
			if (flashStart) begin
				running <= 1'b1;
				count <= doneDelay;
			end else if (running) begin
				if (count == 8'h00) begin
					flashDone <= 1'b1;
					running <= 1'b0;
				end else begin
					count <= count - 8'h01;
				end
			end
		end
	end
endmodule

// File: verification/tb.sv
/*
 Self-checking bench of the flash programming status block.
 Assumes the block answers on AXI4-Lite and a flash model on its far side.
*/
`timescale 1ns/100ps
module tb;
	import flash_isp_pkg::*;
	logic ref_clk = 0, nrst = 0, awvalid = 0, wvalid = 0, bready = 0;
	logic arvalid = 0, rready = 0, regUnlocked = 0, opWrites = 1;
	logic execApp = 0, execLoader = 0;
	logic [7:0] awaddr = 8'h00, araddr = 8'h00, dly = 8'h00;
	logic [31:0] wdata = 32'h0, opAddr = 32'h0, rdata;
	logic [3:0] wstrb = 4'h0;
	logic [11:0] vectorPageMap = 12'h000;
	logic [1:0] configBootSelect = 2'h0, bresp, rresp;
	logic awready, wready, bvalid, arready, rvalid, flashDone, flashStart, irq;
	logic [33:0] rq[$], bq[$];
	logic [31:0] bad[4] = '{32'h200, 32'h10_0010, 32'h30_0000, 32'h20_0000};
	int miscompares = 0, num_checks = 0, starts = 0, cyc = 0;

	flash_isp_status uut (.ref_clk(ref_clk), .nrst(nrst), .awvalid(awvalid),
		.awready(awready), .awaddr(awaddr), .wvalid(wvalid), .wready(wready),
		.wdata(wdata), .wstrb(wstrb), .bvalid(bvalid), .bready(bready),
		.bresp(bresp), .arvalid(arvalid), .arready(arready), .araddr(araddr),
		.rvalid(rvalid), .rready(rready), .rdata(rdata), .rresp(rresp),
		.vectorPageMap(vectorPageMap), .configBootSelect(configBootSelect),
		.regUnlocked(regUnlocked), .opAddr(opAddr), .opWrites(opWrites),
		.execApp(execApp), .execLoader(execLoader), .flashDone(flashDone),
		.flashStart(flashStart), .irq(irq));
	flash_array_model flash (.ref_clk(ref_clk), .nrst(nrst),
		.flashStart(flashStart), .doneDelay(dly), .flashDone(flashDone));

	initial begin
		forever #2.5 ref_clk = ~ref_clk;
	end

	// ---------------------------------------------------------------
	// Compare, report and bus tasks
	// ---------------------------------------------------------------
	task automatic cmp(input string n, input logic [33:0] e,
		input logic [33:0] g);
		num_checks++;
		if (g !== e) begin
			miscompares++;
			$display("CHECK FAILED %s expected %h seen %h", n, e, g);
		end
	endtask

	task results;
		$display("checks %0d miscompares %0d", num_checks, miscompares);
		if (miscompares == 0 && num_checks > 0)
			$display("ALL TESTS PASSED");
		else
			$display("TESTS FAILED");
		$finish;
	endtask

	function automatic logic [31:0] st(input logic f, input logic g);
		st = {11'h000, vectorPageMap, 2'h0, f, 3'h0, configBootSelect, g};
	endfunction

	task automatic wr(input logic [7:0] a, input logic [31:0] d,
		input logic [1:0] r = RESP_OKAY);
		@(posedge ref_clk);
		awaddr <= a;
		wdata <= d;
		wstrb <= 4'hF;
		awvalid <= 1'b1;
		wvalid <= 1'b1;
		bready <= 1'b1;
		bq.push_back({r, 32'h0});
		do begin
			@(posedge ref_clk);
			if (awvalid && awready) awvalid <= 1'b0;
			if (wvalid && wready) wvalid <= 1'b0;
		end while (bvalid !== 1'b1);
		bready <= 1'b0;
	endtask

	task automatic rd(input logic [7:0] a, input logic [31:0] d,
		input logic [1:0] r = RESP_OKAY);
		@(posedge ref_clk);
		araddr <= a;
		arvalid <= 1'b1;
		rready <= 1'b1;
		rq.push_back({r, d});
		do begin
			@(posedge ref_clk);
			if (arvalid && arready) arvalid <= 1'b0;
		end while (rvalid !== 1'b1);
		rready <= 1'b0;
	endtask

	task automatic chkIrq(input logic e);
		@(negedge ref_clk);
		cmp("irq", {33'h0, e}, {33'h0, irq});
		@(posedge ref_clk);
	endtask

	// ---------------------------------------------------------------
	// Output watcher, start counter and timeout
	// ---------------------------------------------------------------
	always @(posedge ref_clk) begin
		cyc++;
		if (flashStart === 1'b1) starts++;
		if (rvalid === 1'b1 && rready === 1'b1)
			cmp("read", rq.size() ? rq.pop_front() : 34'h3_0000_0000,
				{rresp, rdata});
		if (bvalid === 1'b1 && bready === 1'b1)
			cmp("bresp", bq.size() ? bq.pop_front() : 34'h3_0000_0000,
				{bresp, 32'h0});
		if (cyc == 20000) begin
			miscompares++;
			results();
		end
	end

	// ---------------------------------------------------------------
	// Main sequence
	// ---------------------------------------------------------------
	initial begin
		void'($urandom(32'hF7EFE1CD));
		repeat (16) @(posedge ref_clk);
		nrst <= 1'b1;
		rd(ISP_STATUS_OFF, ISP_STATUS_RST);
		rd(CTRL_OFF, 32'h0);
		for (int i = 0; i < 4; i++) begin
			@(posedge ref_clk);
			vectorPageMap <= 12'($urandom());
			configBootSelect <= i[1:0];
			@(posedge ref_clk);
			rd(ISP_STATUS_OFF, st(1'b0, 1'b0));
			wr(ISP_STATUS_OFF, $urandom() & 32'hFFFF_FFBE);
			rd(ISP_STATUS_OFF, st(1'b0, 1'b0));
		end
		wr(8'h20, 32'h1, RESP_SLVERR);
		rd(8'h20, 32'h0, RESP_SLVERR);
		wr(IRQ_MASK_OFF, 32'h3);
		rd(IRQ_MASK_OFF, 32'h3);
		// Slow legal operation, with a second trigger while busy
		dly <= 8'd30;
		opAddr <= 32'h100;
		execLoader <= 1'b1;
		wr(ISP_STATUS_OFF, 32'h1);
		rd(ISP_STATUS_OFF, st(1'b0, 1'b1));
		rd(TRIG_OFF, 32'h1);
		wr(TRIG_OFF, 32'h1);
		repeat (40) @(posedge ref_clk);
		rd(ISP_STATUS_OFF, st(1'b0, 1'b0));
		rd(IRQ_STAT_OFF, 32'h1);
		cmp("starts", 34'd1, 34'(starts));
		chkIrq(1'b1);
		wr(IRQ_MASK_OFF, 32'h0);
		chkIrq(1'b0);
		wr(IRQ_MASK_OFF, 32'h3);
		chkIrq(1'b1);
		wr(IRQ_STAT_OFF, 32'h1);
		chkIrq(1'b0);
		// Refused operations, fail flag set and cleared both ways
		for (int i = 0; i < 4; i++) begin
			opAddr <= bad[i];
			execApp <= (i == 0);
			execLoader <= (i == 1);
			regUnlocked <= 1'b0;
			wr(TRIG_OFF, 32'h1);
			rd(ISP_STATUS_OFF,
				st(1'b1, 1'b0));
			rd(CTRL_OFF, 32'h40);
			chkIrq(1'b1);
			wr(i[0] ? CTRL_OFF : ISP_STATUS_OFF, 32'h40);
			rd(ISP_STATUS_OFF, st(1'b1, 1'b0));
			regUnlocked <= 1'b1;
			wr(ISP_STATUS_OFF, 32'h0);
			rd(ISP_STATUS_OFF, st(1'b1, 1'b0));
			wr(i[0] ? CTRL_OFF : ISP_STATUS_OFF, 32'h40);
			rd(i[0] ? ISP_STATUS_OFF : CTRL_OFF,
				i[0] ? st(1'b0, 1'b0) : 32'h0);
			wr(IRQ_STAT_OFF, 32'h2);
			chkIrq(1'b0);
		end
		cmp("starts", 34'd1, 34'(starts));
		// Config write with update enabled, prompt flash
		wr(CTRL_OFF, 32'h10);
		rd(CTRL_OFF, 32'h10);
		dly <= 8'd0;
		opAddr <= 32'h30_0004;
		execApp <= 1'b0;
		execLoader <= 1'b0;
		wr(ISP_STATUS_OFF, 32'h1);
		repeat (10) @(posedge ref_clk);
		rd(ISP_STATUS_OFF, st(1'b0, 1'b0));
		rd(IRQ_STAT_OFF, 32'h1);
		cmp("starts", 34'd2, 34'(starts));
		// Non-writing operation from the running region is legal
		opWrites <= 1'b0;
		opAddr <= 32'h100;
		execApp <= 1'b1;
		wr(TRIG_OFF, 32'h1);
		repeat (10) @(posedge ref_clk);
		rd(ISP_STATUS_OFF, st(1'b0, 1'b0));
		cmp("starts", 34'd3, 34'(starts));
		results();
	end
endmodule
